// ---- src/tos_defs.vh ----
`ifndef TOS_DEFS_VH
`define TOS_DEFS_VH

// ----------------------------------------
// Program cycle and timing
// ----------------------------------------
`define TOS_CLK_KHZ 20000
`define TOS_CYCLE_US 5000
`define TOS_CYCLE_CLKS ((`TOS_CYCLE_US * `TOS_CLK_KHZ) / 1000)
`define TOS_TRIP_STEP_US 5000
`define TOS_TRIP_DELAY_MAX 20'h A_FC80

// ----------------------------------------
// Threshold defaults, units of 0.1 percent; trip delay default in program cycles
// ----------------------------------------
`define TOS_ALARM1_DEF 11'h 190
`define TOS_ALARM2_DEF 11'h 190
`define TOS_INHIBIT_DEF 11'h 320
`define TOS_TRIP_DEF 11'h 3E8
`define TOS_TRIP_DELAY_DEF 20'h 0_0000

// ----------------------------------------
// Current scale, units of 0.01 x nominal
// ----------------------------------------
`define TOS_CUR_ONE_PCT 16'h 0001
`define TOS_CUR_TWICE_NOM 16'h 00C8
`define TOS_UNITY 16'h 0064
`define TOS_SF_MAX 16'h 01F4
`define TOS_K_MAX 16'h 01F4

// ----------------------------------------
// Behaviour modes
// ----------------------------------------
`define TOS_MODE_ON 3'h 0
`define TOS_MODE_BLOCKED 3'h 1
`define TOS_MODE_TEST 3'h 2
`define TOS_MODE_TEST_BLK 3'h 3
`define TOS_MODE_OFF 3'h 4

// ----------------------------------------
// Operating condition codes
// ----------------------------------------
`define TOS_COND_NORMAL 3'h 0
`define TOS_COND_ALARM1 3'h 1
`define TOS_COND_ALARM2 3'h 2
`define TOS_COND_INHIBIT 3'h 3
`define TOS_COND_TRIP 3'h 4
`define TOS_COND_BLOCKED 3'h 5

// ----------------------------------------
// Thermal status codes
// ----------------------------------------
`define TOS_LOAD_LIGHT 2'h 0
`define TOS_LOAD_NORMAL 2'h 1
`define TOS_LOAD_OVER 2'h 2
`define TOS_LOAD_HIGH 2'h 3

// ----------------------------------------
// I/O output bit positions
// ----------------------------------------
`define TOS_IO_ALARM1 0
`define TOS_IO_ALARM2 1
`define TOS_IO_INHIBIT 2
`define TOS_IO_TRIP 3

`endif

// ---- src/tos_trip_delay.v ----
`timescale 1ns/1ps
`include "tos_defs.vh"

module tos_trip_delay #(
    parameter DLY_W = 20
) (
    // Clock and reset
    input wire sysClk,
    input wire resetn,
    // Control
    input wire tick,
    input wire run,
    input wire [DLY_W-1:0] delaySet,
    // Result
    output wire done
);

    reg [DLY_W-1:0] count;

    // ----------------------------------------
    // Program cycles counted since start
    // ----------------------------------------
    always @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            count <= {DLY_W{1'b0}};
        end else if (tick) begin
            if (!run) begin
                count <= {DLY_W{1'b0}};
            end else if (count < delaySet) begin
                count <= count + {{(DLY_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // Zero setting completes at once
    assign done = run && (count >= delaySet);

endmodule

// ---- src/tos_load_band.v ----
`timescale 1ns/1ps
`include "tos_defs.vh"

module tos_load_band #(
    parameter CUR_W = 16
) (
    // Measured and pick-up current
    input wire [CUR_W-1:0] measCurrent,
    input wire [CUR_W-1:0] pickCurrent,
    // Classification
    output reg [1:0] loadBand
);

    always @* begin
        loadBand = `TOS_LOAD_NORMAL;
        // R13 light load
        if (measCurrent < `TOS_CUR_ONE_PCT) begin
            loadBand = `TOS_LOAD_LIGHT;
        // R14 load bands
        end else if (measCurrent > `TOS_CUR_TWICE_NOM) begin
            loadBand = `TOS_LOAD_HIGH;
        end else if (measCurrent > pickCurrent) begin
            loadBand = `TOS_LOAD_OVER;
        end else begin
            loadBand = `TOS_LOAD_NORMAL;
        end
    end

endmodule

// ---- src/tos_stage.v ----
// Function
// R1 - Alarm 1 rises when capacity reaches its threshold, 0.1 % steps, default 40 %.
// R2 - Alarm 2 rises at its own threshold, default 40 %.
// R3 - Restart inhibit rises at its threshold, default 80 %.
// R4 - Trip condition rises at trip threshold, default 100 %.
// R5 - Each output has its own enable; disabled drives neither signal nor I/O.
// R6 - Trip postponed by extra delay in 5 ms steps; zero adds none.
// R7 - Block input sampled once at start of every program cycle.
// R8 - Pick-up without block gives start and runs operate timing.
// R9 - Pick-up with block gives blocked and nothing further.
// R10 - Block arriving during start clears start like a pick-up reset.
// R11 - Blocking party asserts block at least 5 ms before delay expiry.
// R12 - Report operating condition; normal condition drives no outputs.
// R13 - Report light or no load below one percent of nominal.
// R14 - Report load normal, overloading, or high overload above twice nominal.
// R15 - Invalid service factor replaced by 1.0 with a live fault flag.
// R16 - Inconsistent ambient settings give correction 1.0 with a live fault flag.
// R17 - Behaviour mode: on, blocked, test, test-blocked, off.
// R18 - New setting-group values apply immediately while running.
// R19 - Threshold outputs drop below threshold, evaluated once per program cycle.
`timescale 1ns/1ps
`include "tos_defs.vh"

module tos_stage #(
    parameter CAP_W = 11,
    parameter CUR_W = 16,
    parameter DLY_W = 20,
    parameter CYCLE_CLKS = `TOS_CYCLE_CLKS
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Thermal image and currents
    input wire [CAP_W-1:0] thermCap,
    input wire [CUR_W-1:0] measCurrent,
    input wire [CUR_W-1:0] pickCurrent,
    // Blocking matrix input
    input wire blockIn,
    // Active setting group values
    input wire [2:0] behaviourMode,
    input wire alarm1En,
    input wire alarm2En,
    input wire inhibitEn,
    input wire tripEn,
    input wire [CAP_W-1:0] alarm1Level,
    input wire [CAP_W-1:0] alarm2Level,
    input wire [CAP_W-1:0] inhibitLevel,
    input wire [CAP_W-1:0] tripLevel,
    input wire [DLY_W-1:0] tripDelay,
    input wire [CUR_W-1:0] serviceFactor,
    input wire signed [CUR_W-1:0] ambTempMin,
    input wire signed [CUR_W-1:0] ambTempMax,
    input wire [CUR_W-1:0] ambKMin,
    input wire [CUR_W-1:0] ambKMax,
    // Stage signals
    output reg alarm1Sig,
    output reg alarm2Sig,
    output reg inhibitSig,
    output reg tripSig,
    output reg startSig,
    output reg blockedSig,
    output reg [3:0] ioOut,
    output reg cycleTick,
    output reg blockSample,
    // Status
    output reg [2:0] condition,
    output reg [1:0] loadBand,
    output reg factorFault,
    output reg ambFault,
    output reg [CUR_W-1:0] usedServiceFactor,
    output reg [CUR_W-1:0] usedAmbK
);

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    function reached;
        input en;
        input [CAP_W-1:0] cap;
        input [CAP_W-1:0] lvl;
        begin
            reached = en && (cap >= lvl);
        end
    endfunction

    function kBad;
        input [CUR_W-1:0] k;
        begin
            kBad = (k == {CUR_W{1'b0}}) || (k > `TOS_K_MAX);
        end
    endfunction

    // ----------------------------------------
    // Program cycle timer
    // ----------------------------------------
    localparam [31:0] LAST_CLK = CYCLE_CLKS - 1;

    reg [31:0] cycleCount;
    wire tickNow;

    assign tickNow = (cycleCount == LAST_CLK);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cycleCount <= 32'h 0000_0000;
        end else if (tickNow) begin
            cycleCount <= 32'h 0000_0000;
        end else begin
            cycleCount <= cycleCount + 32'h 0000_0001;
        end
    end

    // ----------------------------------------
    // Mode decoding
    // ----------------------------------------
    wire modeOff;
    wire modeBlk;
    wire modeTest;

    // R17 behaviour mode
    assign modeOff = (behaviourMode == `TOS_MODE_OFF) || (behaviourMode > `TOS_MODE_OFF);
    assign modeBlk = (behaviourMode == `TOS_MODE_BLOCKED) ||
                     (behaviourMode == `TOS_MODE_TEST_BLK);
    assign modeTest = (behaviourMode == `TOS_MODE_TEST) ||
                      (behaviourMode == `TOS_MODE_TEST_BLK);

    // ----------------------------------------
    // Threshold comparisons
    // ----------------------------------------
    wire a1Hit;
    wire a2Hit;
    wire inhHit;
    wire pickUp;
    wire blockNow;

    // R1 alarm 1 threshold
    assign a1Hit = reached(alarm1En, thermCap, alarm1Level) && !modeOff;
    // R2 alarm 2 threshold
    assign a2Hit = reached(alarm2En, thermCap, alarm2Level) && !modeOff;
    // R3 inhibit threshold
    assign inhHit = reached(inhibitEn, thermCap, inhibitLevel) && !modeOff;
    // R4 trip pick-up
    assign pickUp = reached(tripEn, thermCap, tripLevel) && !modeOff;
    // R7 block taken at cycle start
    assign blockNow = blockIn || modeBlk;

    // ----------------------------------------
    // Trip delay
    // ----------------------------------------
    wire delayDone;

    // R6 extra trip delay
    tos_trip_delay #(
        .DLY_W(DLY_W)
    ) u_delay (
        .sysClk(sys_clk),
        .resetn(resetn),
        .tick(tickNow),
        .run(startSig),
        .delaySet(tripDelay),
        .done(delayDone)
    );

    // ----------------------------------------
    // Start, blocked and outputs per cycle
    // ----------------------------------------
    reg next_start;
    reg next_blocked;
    reg next_trip;

    always @* begin
        next_start = 1'b0;
        next_blocked = 1'b0;
        next_trip = 1'b0;
        if (pickUp) begin
            if (blockNow) begin
                // R9 blocked indication
                next_blocked = 1'b1;
                // R10 start released by block
                next_start = 1'b0;
            end else begin
                // R8 start and operate timing
                next_start = 1'b1;
                next_trip = startSig && delayDone;
            end
        end
    end

    // R19 evaluated each program cycle
    // R18 settings used as they stand
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alarm1Sig <= 1'b0;
            alarm2Sig <= 1'b0;
            inhibitSig <= 1'b0;
            tripSig <= 1'b0;
            startSig <= 1'b0;
            blockedSig <= 1'b0;
            blockSample <= 1'b0;
        end else if (tickNow) begin
            alarm1Sig <= a1Hit;
            alarm2Sig <= a2Hit;
            inhibitSig <= inhHit;
            tripSig <= next_trip;
            startSig <= next_start;
            blockedSig <= next_blocked;
            blockSample <= blockIn;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cycleTick <= 1'b0;
        end else begin
            cycleTick <= tickNow;
        end
    end

    // ----------------------------------------
    // Operating condition and I/O
    // ----------------------------------------
    reg [2:0] next_condition;

    always @* begin
        next_condition = `TOS_COND_NORMAL;
        if (blockedSig) begin
            next_condition = `TOS_COND_BLOCKED;
        end else if (tripSig) begin
            next_condition = `TOS_COND_TRIP;
        end else if (inhibitSig) begin
            next_condition = `TOS_COND_INHIBIT;
        end else if (alarm2Sig) begin
            next_condition = `TOS_COND_ALARM2;
        end else if (alarm1Sig) begin
            next_condition = `TOS_COND_ALARM1;
        end
    end

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            condition <= `TOS_COND_NORMAL;
            ioOut <= 4'h 0;
        end else begin
            // R12 condition report
            condition <= next_condition;
            // R5 disabled outputs stay off
            // R12 normal drives no I/O
            if (modeTest || modeOff) begin
                ioOut <= 4'h 0;
            end else begin
                ioOut[`TOS_IO_ALARM1] <= alarm1Sig && alarm1En;
                ioOut[`TOS_IO_ALARM2] <= alarm2Sig && alarm2En;
                ioOut[`TOS_IO_INHIBIT] <= inhibitSig && inhibitEn;
                ioOut[`TOS_IO_TRIP] <= tripSig && tripEn;
            end
        end
    end

    // ----------------------------------------
    // Thermal status
    // ----------------------------------------
    wire [1:0] bandNow;

    tos_load_band #(
        .CUR_W(CUR_W)
    ) u_band (
        .measCurrent(measCurrent),
        .pickCurrent(pickCurrent),
        .loadBand(bandNow)
    );

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            loadBand <= `TOS_LOAD_LIGHT;
        end else begin
            // R13 light load report
            // R14 load band report
            loadBand <= bandNow;
        end
    end

    // ----------------------------------------
    // Setting faults
    // ----------------------------------------
    wire factorBad;
    wire ambBad;

    assign factorBad = kBad(serviceFactor);
    assign ambBad = (ambTempMin >= ambTempMax) || kBad(ambKMin) || kBad(ambKMax);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            factorFault <= 1'b0;
            ambFault <= 1'b0;
            usedServiceFactor <= `TOS_UNITY;
            usedAmbK <= `TOS_UNITY;
        end else begin
            // R15 service factor override
            factorFault <= factorBad;
            usedServiceFactor <= factorBad ? `TOS_UNITY : serviceFactor;
            // R16 ambient override
            ambFault <= ambBad;
            usedAmbK <= ambBad ? `TOS_UNITY : ambKMax;
        end
    end

endmodule

// ---- test/tos_stage_monitor.sv ----
`timescale 1ns/1ps
`include "tos_defs.vh"

module tos_stage_monitor #(
    parameter CAP_W = 11,
    parameter CUR_W = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire resetn,
    // Watched inputs
    input wire [CAP_W-1:0] thermCap,
    input wire [CUR_W-1:0] measCurrent,
    input wire [2:0] behaviourMode,
    input wire alarm1En,
    input wire [CAP_W-1:0] alarm1Level,
    input wire [CUR_W-1:0] serviceFactor,
    input wire signed [CUR_W-1:0] ambTempMin,
    input wire signed [CUR_W-1:0] ambTempMax,
    // Watched outputs
    input wire alarm1Sig,
    input wire alarm2Sig,
    input wire inhibitSig,
    input wire tripSig,
    input wire startSig,
    input wire blockedSig,
    input wire [3:0] ioOut,
    input wire cycleTick,
    input wire blockSample,
    input wire [2:0] condition,
    input wire [1:0] loadBand,
    input wire factorFault,
    input wire ambFault,
    input wire [CUR_W-1:0] usedServiceFactor,
    input wire [CUR_W-1:0] usedAmbK
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    // ----------------------------------------
    // Sequences
    // ----------------------------------------
    sequence tickSeq;
        cycleTick;
    endsequence
    sequence liveSeq;
        $past(resetn);
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    chk_alarm1_reach: assert property (tickSeq ##0 ($past(behaviourMode) == `TOS_MODE_ON)
        |-> alarm1Sig == ($past(alarm1En) && $past(thermCap) >= $past(alarm1Level)))
        else $error("alarm 1 wrong");
    chk_block_start: assert property (tickSeq ##0 blockSample |-> !startSig && !tripSig)
        else $error("start while blocked");
    chk_trip_after: assert property ($rose(tripSig) |-> $past(startSig))
        else $error("trip without start");
    chk_hold_between: assert property (!cycleTick
        |-> $stable({alarm1Sig, alarm2Sig, inhibitSig, tripSig, startSig, blockedSig}))
        else $error("stage signal moved off tick");
    chk_normal_quiet: assert property (condition == `TOS_COND_NORMAL |-> ioOut == 4'h0)
        else $error("outputs in normal");
    chk_off_silent: assert property (tickSeq ##0 ($past(behaviourMode) == `TOS_MODE_OFF)
        |-> {alarm1Sig, alarm2Sig, inhibitSig, tripSig, startSig, blockedSig} == 6'h00)
        else $error("signal in off mode");
    chk_light_load: assert property (liveSeq ##0 ($past(measCurrent) < `TOS_CUR_ONE_PCT)
        |-> loadBand == `TOS_LOAD_LIGHT)
        else $error("light load missed");
    chk_high_load: assert property (liveSeq ##0 ($past(measCurrent) > `TOS_CUR_TWICE_NOM)
        |-> loadBand == `TOS_LOAD_HIGH)
        else $error("high overload missed");
    chk_factor_subst: assert property (liveSeq ##0 ($past(serviceFactor) == 16'h0000)
        |-> factorFault && usedServiceFactor == `TOS_UNITY)
        else $error("service factor fault missed");
    chk_amb_subst: assert property (liveSeq ##0 $past(ambTempMin >= ambTempMax)
        |-> ambFault && usedAmbK == `TOS_UNITY)
        else $error("ambient fault missed");
endmodule

bind tos_stage tos_stage_monitor #(.CAP_W(CAP_W), .CUR_W(CUR_W)) mon_u (
    .sys_clk(sys_clk), .resetn(resetn), .thermCap(thermCap), .measCurrent(measCurrent),
    .behaviourMode(behaviourMode), .alarm1En(alarm1En), .alarm1Level(alarm1Level),
    .serviceFactor(serviceFactor), .ambTempMin(ambTempMin), .ambTempMax(ambTempMax),
    .alarm1Sig(alarm1Sig), .alarm2Sig(alarm2Sig), .inhibitSig(inhibitSig),
    .tripSig(tripSig), .startSig(startSig), .blockedSig(blockedSig), .ioOut(ioOut),
    .cycleTick(cycleTick), .blockSample(blockSample), .condition(condition),
    .loadBand(loadBand), .factorFault(factorFault), .ambFault(ambFault),
    .usedServiceFactor(usedServiceFactor), .usedAmbK(usedAmbK)
);

// ---- test/tos_block_src.sv ----
`timescale 1ns/1ps

module tos_block_src (
    // Clock and reset
    input wire sysClk,
    input wire resetn,
    // Bench request
    input wire blockReq,
    // Blocking matrix line
    output reg blockIn
);
    always @(posedge sysClk or negedge resetn) begin
        if (!resetn) begin
            blockIn <= 1'b0;
        end else begin
            blockIn <= blockReq;
        end
    end
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
`include "tos_defs.vh"
`define CHK(g, e) checkVal(g, e)

module testbench;
    reg sysClk, resetn, blockReq, alarm1En, alarm2En, inhibitEn, tripEn;
    reg [2:0] behaviourMode;
    reg [10:0] thermCap, alarm1Level, alarm2Level, inhibitLevel, tripLevel;
    reg [15:0] measCurrent, pickCurrent, serviceFactor, ambKMin, ambKMax;
    reg signed [15:0] ambTempMin, ambTempMax;
    reg [19:0] tripDelay;
    wire blockIn, alarm1Sig, alarm2Sig, inhibitSig, tripSig, startSig, blockedSig;
    wire cycleTick, blockSample, factorFault, ambFault;
    wire [3:0] ioOut;
    wire [2:0] condition;
    wire [1:0] loadBand;
    wire [15:0] usedServiceFactor, usedAmbK;
    integer badCount, testsRun, n, k;

    tos_block_src src_u (.sysClk(sysClk), .resetn(resetn), .blockReq(blockReq), .blockIn(blockIn));

    tos_stage #(.CYCLE_CLKS(8)) dut_u (
        .sys_clk(sysClk), .resetn(resetn), .thermCap(thermCap), .measCurrent(measCurrent),
        .pickCurrent(pickCurrent), .blockIn(blockIn), .behaviourMode(behaviourMode),
        .alarm1En(alarm1En), .alarm2En(alarm2En), .inhibitEn(inhibitEn), .tripEn(tripEn),
        .alarm1Level(alarm1Level), .alarm2Level(alarm2Level), .inhibitLevel(inhibitLevel),
        .tripLevel(tripLevel), .tripDelay(tripDelay), .serviceFactor(serviceFactor),
        .ambTempMin(ambTempMin), .ambTempMax(ambTempMax), .ambKMin(ambKMin), .ambKMax(ambKMax),
        .alarm1Sig(alarm1Sig), .alarm2Sig(alarm2Sig), .inhibitSig(inhibitSig),
        .tripSig(tripSig), .startSig(startSig), .blockedSig(blockedSig), .ioOut(ioOut),
        .cycleTick(cycleTick), .blockSample(blockSample), .condition(condition),
        .loadBand(loadBand), .factorFault(factorFault), .ambFault(ambFault),
        .usedServiceFactor(usedServiceFactor), .usedAmbK(usedAmbK)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task checkVal(input [31:0] got, input [31:0] exp);
        begin
            testsRun = testsRun + 1;
            if (got !== exp) begin
                badCount = badCount + 1;
                $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
            end
        end
    endtask

    task finishTest;
        begin
            $display("checks %0d mismatches %0d", testsRun, badCount);
            if (badCount == 0 && testsRun > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask

    // Ends on the falling edge where the fresh tick is visible
    task waitTick;
        integer i;
        begin
            i = 0;
            @(negedge sysClk);
            while (cycleTick !== 1'b1) begin
                i = i + 1;
                if (i > 40) begin
                    badCount = badCount + 1;
                    finishTest;
                end
                @(negedge sysClk);
            end
        end
    endtask

    task settle;
        repeat (2) @(negedge sysClk);
    endtask

    task checkCap(input [10:0] cap);
        begin
            thermCap = cap;
            waitTick;
            `CHK({inhibitSig, alarm2Sig, alarm1Sig}, {cap >= inhibitLevel, cap >= alarm2Level, cap >= alarm1Level});
        end
    endtask

    task setLoad(input [15:0] cur, input [1:0] exp);
        begin
            measCurrent = cur;
            settle;
            `CHK(loadBand, exp);
        end
    endtask

    initial begin
        sysClk = 1'b0;
        forever #25 sysClk = ~sysClk;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        badCount = 0;
        testsRun = 0;
        resetn = 1'b0;
        blockReq = 1'b0;
        behaviourMode = `TOS_MODE_ON;
        {alarm1En, alarm2En, inhibitEn, tripEn} = 4'hF;
        alarm1Level = `TOS_ALARM1_DEF;
        alarm2Level = 11'h1F4;
        inhibitLevel = `TOS_INHIBIT_DEF;
        tripLevel = `TOS_TRIP_DEF;
        tripDelay = `TOS_TRIP_DELAY_DEF;
        thermCap = 11'h000;
        measCurrent = 16'h0032;
        pickCurrent = 16'h0064;
        serviceFactor = `TOS_UNITY;
        ambTempMin = 16'sh0000;
        ambTempMax = 16'sh002D;
        ambKMin = `TOS_UNITY;
        ambKMax = 16'h0050;
        repeat (3) @(negedge sysClk);
        resetn = 1'b1;
        setLoad(16'h0000, `TOS_LOAD_LIGHT);
        setLoad(16'h0032, `TOS_LOAD_NORMAL);
        setLoad(16'h0096, `TOS_LOAD_OVER);
        setLoad(16'h00FA, `TOS_LOAD_HIGH);
        serviceFactor = 16'h0000;
        settle;
        `CHK({factorFault, usedServiceFactor}, {1'b1, `TOS_UNITY});
        serviceFactor = 16'h0258;
        settle;
        `CHK({factorFault, usedServiceFactor}, {1'b1, `TOS_UNITY});
        serviceFactor = 16'h0078;
        settle;
        `CHK({factorFault, usedServiceFactor}, {1'b0, 16'h0078});
        ambTempMin = 16'sh0032;
        settle;
        `CHK({ambFault, usedAmbK}, {1'b1, `TOS_UNITY});
        ambTempMin = 16'sh0000;
        settle;
        `CHK({ambFault, usedAmbK}, {1'b0, ambKMax});
        checkCap(11'h18F);
        checkCap(11'h190);
        checkCap(11'h1F4);
        checkCap(11'h31F);
        checkCap(11'h320);
        @(negedge sysClk);
        `CHK(ioOut, 4'h7);
        `CHK(condition, `TOS_COND_INHIBIT);
        inhibitEn = 1'b0;
        waitTick;
        @(negedge sysClk);
        `CHK({inhibitSig, ioOut}, {1'b0, 4'h3});
        inhibitEn = 1'b1;
        alarm1Level = 11'h3E7;
        checkCap(11'h190);
        alarm1Level = `TOS_ALARM1_DEF;
        checkCap(11'h000);
        @(negedge sysClk);
        `CHK({condition, ioOut}, {`TOS_COND_NORMAL, 4'h0});
        thermCap = `TOS_TRIP_DEF;
        waitTick;
        `CHK({startSig, tripSig}, 2'b10);
        waitTick;
        @(negedge sysClk);
        `CHK({tripSig, ioOut, condition}, {1'b1, 4'hF, `TOS_COND_TRIP});
        blockReq = 1'b1;
        waitTick;
        `CHK({startSig, tripSig, blockedSig, blockSample}, 4'h3);
        @(negedge sysClk);
        `CHK({condition, ioOut[3]}, {`TOS_COND_BLOCKED, 1'b0});
        blockReq = 1'b0;
        waitTick;
        `CHK({startSig, blockedSig}, 2'b10);
        @(negedge sysClk);
        blockReq = 1'b1;
        @(negedge sysClk);
        blockReq = 1'b0;
        waitTick;
        `CHK({tripSig, blockSample}, 2'b10);
        thermCap = 11'h000;
        waitTick;
        tripDelay = 20'h0_0003;
        thermCap = `TOS_TRIP_DEF;
        n = 0;
        for (k = 1; k <= 7; k = k + 1) begin
            waitTick;
            if (tripSig === 1'b1 && n == 0) begin
                n = k;
            end
        end
        `CHK(n, 5);
        thermCap = 11'h1F4;
        for (k = 0; k <= 4; k = k + 1) begin
            behaviourMode = k[2:0];
            waitTick;
            @(negedge sysClk);
            `CHK({ioOut[0], alarm1Sig}, {k < 2, k != 4});
        end
        behaviourMode = `TOS_MODE_BLOCKED;
        thermCap = `TOS_TRIP_DEF;
        waitTick;
        `CHK({startSig, blockedSig}, 2'b01);
        finishTest;
    end
endmodule
